/* verilog/mmap_defines.svh */
// address map constants for the memory space decoder
`ifndef MMAP_DEFINES_SVH
`define MMAP_DEFINES_SVH
`define MMAP_SIZE_RESET 8'hCF
`define MMAP_SIZE_SMALL 8'h42
`define MMAP_SIZE_16K 8'h44
`define MMAP_SIZE_24K 8'hC6
`define MMAP_SIZE_32K 8'hC8
`define MMAP_VEC_LAST 16'h003F
`define MMAP_VEC_RESET 16'h0000
`define MMAP_VEC_LVI 16'h0004
`define MMAP_VEC_MAX 16'h0030
`define MMAP_CT_FIRST 16'h0040
`define MMAP_CT_LAST 16'h007F
`define MMAP_OPT_ADDR 16'h0080
`define MMAP_CF_FIRST 16'h0800
`define MMAP_CF_LAST 16'h0FFF
`define MMAP_FL_END_SMALL 16'h3FFF
`define MMAP_FL_END_16K 16'h3FFF
`define MMAP_FL_END_24K 16'h5FFF
`define MMAP_FL_END_32K 16'h7FFF
`define MMAP_RAM_BEG_512 16'hFD00
`define MMAP_RAM_BEG_1K 16'hFB00
`define MMAP_GPR_FIRST 16'hFEE0
`define MMAP_SFR_FIRST 16'hFF00
`endif

/* verilog/mmap_pkg.sv */
// types for the memory space decoder
`default_nettype none
package mmap_pkg;
    typedef enum logic [2:0] {
        MMAP_REG_NONE = 3'b000,
        MMAP_REG_FLASH = 3'b001,
        MMAP_REG_RAM = 3'b010,
        MMAP_REG_GPR = 3'b011,
        MMAP_REG_SFR = 3'b100
    } mmap_region_e;
endpackage
`default_nettype wire

/* verilog/mmap_decoder.sv */
// memory space region decoder with size switching and vector fetch
// How it works
// - one flat 16-bit 64 KB space
// - size select resets to CFH
// - 0000H-003FH is the vector table
// - vector low byte even, high odd
// - reset vector 0000H, sources to 0030H
// - table call entries at 0040H-007FH
// - option byte read at 0080H
// - short direct call targets 0800H-0FFFH
// - flash ends 3FFFH, 5FFFH or 7FFFH
// - RAM ends FEFFH, starts FD00H/FB00H
// - register banks at FEE0H-FEFFH
// - FF00H-FFFFH selects peripheral registers
// - fetches addressed by program counter
// - RAM usable as stack memory
// - reset loads counter from 0000H/0001H
`timescale 1ns/1ns
`default_nettype none
`include "mmap_defines.svh"
module mmap_decoder
    import mmap_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic fetch,
    input wire logic size_wr,
    input wire logic [7:0] size_wdata,
    input wire logic [5:0] vec_offset,
    input wire logic vec_req,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] memory_size_select,
    output logic [2:0] region,
    output logic in_vector,
    output logic in_table_call,
    output logic in_option_byte,
    output logic short_call_ok,
    output logic stack_ok,
    output logic fetch_fault,
    output logic unmapped,
    output logic [15:0] vec_addr,
    output logic [15:0] vector,
    output logic vec_done
);
    typedef enum logic [1:0] {
        MMAP_V_IDLE = 2'b00,
        MMAP_V_LOW = 2'b01,
        MMAP_V_HIGH = 2'b10,
        MMAP_V_DONE = 2'b11
    } mmap_vstate_e;

    mmap_vstate_e vstate;
    mmap_vstate_e next_vstate;
    logic [7:0] vec_low;
    logic [15:0] vec_base;
    // reset vector is fetched straight out of reset
    logic boot;

    // flash top and RAM base follow the programmed size
    wire [15:0] flash_end;
    wire [15:0] ram_beg;
    assign flash_end = (memory_size_select == `MMAP_SIZE_32K) ? `MMAP_FL_END_32K :
                       (memory_size_select == `MMAP_SIZE_24K) ? `MMAP_FL_END_24K :
                       (memory_size_select == `MMAP_SIZE_16K) ? `MMAP_FL_END_16K :
                       (memory_size_select == `MMAP_SIZE_SMALL) ? `MMAP_FL_END_SMALL :
                       `MMAP_FL_END_32K;
    assign ram_beg = (memory_size_select == `MMAP_SIZE_16K ||
                      memory_size_select == `MMAP_SIZE_SMALL) ?
                     `MMAP_RAM_BEG_512 : `MMAP_RAM_BEG_1K;

    wire is_flash = addr <= flash_end;
    wire is_sfr = addr >= `MMAP_SFR_FIRST;
    wire is_gpr = addr >= `MMAP_GPR_FIRST && !is_sfr;
    wire is_ram = addr >= ram_beg && !is_gpr && !is_sfr;
    wire [2:0] next_region = is_sfr ? MMAP_REG_SFR :
                             is_gpr ? MMAP_REG_GPR :
                             is_ram ? MMAP_REG_RAM :
                             is_flash ? MMAP_REG_FLASH : MMAP_REG_NONE;
    wire next_in_vector = addr <= `MMAP_VEC_LAST;
    wire next_in_tcall = addr >= `MMAP_CT_FIRST && addr <= `MMAP_CT_LAST;
    wire next_in_opt = addr == `MMAP_OPT_ADDR;
    wire next_scall = addr >= `MMAP_CF_FIRST && addr <= `MMAP_CF_LAST;
    // stack lives in RAM incl banks
    wire next_stack = is_ram || is_gpr;
    // fetch only from flash or plain RAM
    wire next_fault = fetch && !(is_flash || is_ram);

    // offsets past the last source fall back to the reset vector
    wire [15:0] req_base = {10'h000, vec_offset[5:1], 1'b0};
    wire [15:0] clamp_base = (req_base > `MMAP_VEC_MAX) ? `MMAP_VEC_RESET : req_base;

    always_comb begin
        next_vstate = vstate;
        unique case (vstate)
            MMAP_V_IDLE: begin
                if (vec_req || boot) begin
                    next_vstate = MMAP_V_LOW;
                end
            end
            MMAP_V_LOW: next_vstate = MMAP_V_HIGH;
            MMAP_V_HIGH: next_vstate = MMAP_V_DONE;
            MMAP_V_DONE: next_vstate = MMAP_V_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            memory_size_select <= `MMAP_SIZE_RESET;
        end else if (size_wr) begin
            memory_size_select <= size_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            region <= MMAP_REG_NONE;
            in_vector <= 1'b0;
            in_table_call <= 1'b0;
            in_option_byte <= 1'b0;
            short_call_ok <= 1'b0;
            stack_ok <= 1'b0;
            fetch_fault <= 1'b0;
            unmapped <= 1'b0;
        end else begin
            region <= next_region;
            in_vector <= next_in_vector;
            in_table_call <= next_in_tcall;
            in_option_byte <= next_in_opt;
            short_call_ok <= next_scall;
            stack_ok <= next_stack;
            fetch_fault <= next_fault;
            unmapped <= next_region == MMAP_REG_NONE;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            vstate <= MMAP_V_IDLE;
            boot <= 1'b1;
            vec_base <= `MMAP_VEC_RESET;
            vec_addr <= `MMAP_VEC_RESET;
            vec_low <= 8'h00;
            vector <= 16'h0000;
            vec_done <= 1'b0;
        end else begin
            vstate <= next_vstate;
            vec_done <= 1'b0;
            if (vstate == MMAP_V_IDLE && (vec_req || boot)) begin
                vec_base <= boot ? `MMAP_VEC_RESET : clamp_base;
                vec_addr <= boot ? `MMAP_VEC_RESET : clamp_base;
                boot <= 1'b0;
            end
            // low byte even, high byte odd
            if (vstate == MMAP_V_LOW) begin
                vec_low <= mem_rdata;
                vec_addr <= vec_base + 16'h0001;
            end
            if (vstate == MMAP_V_HIGH) begin
                vector <= {mem_rdata, vec_low};
                vec_done <= 1'b1;
            end
        end
    end

    property p_size_reset;
        @(posedge core_clk) $fell(rst) |-> memory_size_select == `MMAP_SIZE_RESET;
    endproperty
    a_size_reset: assert property (p_size_reset) else $error("size reset wrong");

    property p_sfr;
        @(posedge core_clk) disable iff (rst)
            (!$past(rst) && $past(addr) >= `MMAP_SFR_FIRST) |-> region == MMAP_REG_SFR;
    endproperty
    a_sfr: assert property (p_sfr) else $error("sfr decode wrong");

    property p_gpr;
        @(posedge core_clk) disable iff (rst)
            (!$past(rst) && $past(addr) >= `MMAP_GPR_FIRST && $past(addr) < `MMAP_SFR_FIRST)
            |-> region == MMAP_REG_GPR;
    endproperty
    a_gpr: assert property (p_gpr) else $error("bank decode wrong");

    property p_vec;
        @(posedge core_clk) disable iff (rst)
            !$past(rst) |-> in_vector == ($past(addr) <= `MMAP_VEC_LAST);
    endproperty
    a_vec: assert property (p_vec) else $error("vector window wrong");

    property p_tcall;
        @(posedge core_clk) disable iff (rst)
            !$past(rst) |-> in_table_call == ($past(addr) >= `MMAP_CT_FIRST &&
                                              $past(addr) <= `MMAP_CT_LAST);
    endproperty
    a_tcall: assert property (p_tcall) else $error("table call window wrong");

    property p_scall;
        @(posedge core_clk) disable iff (rst)
            !$past(rst) |-> short_call_ok == ($past(addr) >= `MMAP_CF_FIRST &&
                                              $past(addr) <= `MMAP_CF_LAST);
    endproperty
    a_scall: assert property (p_scall) else $error("short call window wrong");

    property p_flash32;
        @(posedge core_clk) disable iff (rst)
            ($past(memory_size_select) == `MMAP_SIZE_32K && $past(addr) == `MMAP_FL_END_32K)
            |-> region == MMAP_REG_FLASH;
    endproperty
    a_flash32: assert property (p_flash32) else $error("flash end wrong");

    property p_ram512;
        @(posedge core_clk) disable iff (rst)
            ($past(memory_size_select) == `MMAP_SIZE_16K &&
             $past(addr) == `MMAP_RAM_BEG_512 - 16'h0001)
            |-> region == MMAP_REG_NONE;
    endproperty
    a_ram512: assert property (p_ram512) else $error("ram base wrong");

    property p_vec_order;
        @(posedge core_clk) disable iff (rst)
            vstate == MMAP_V_LOW |=> vec_addr[0] ##1 (vec_done && vector[7:0] == $past(vec_low));
    endproperty
    a_vec_order: assert property (p_vec_order) else $error("vector byte order wrong");

    property p_boot;
        @(posedge core_clk) $fell(rst) |-> ##1 vec_addr == `MMAP_VEC_RESET ##2 vec_done;
    endproperty
    a_boot: assert property (p_boot) else $error("reset vector not fetched");
endmodule
`default_nettype wire

/* tb/mmap_mem_model.sv */
// vector memory answering the decoder's byte reads
`timescale 1ns/1ns
`default_nettype none
module mmap_mem_model (
    input wire logic [15:0] vec_addr,
    output logic [7:0] mem_rdata
);
    assign mem_rdata = {vec_addr[3:0], vec_addr[7:4]} ^ 8'hC3;
endmodule
`default_nettype wire

/* tb/mmap_decoder_test.sv */
// self-checking bench for the memory space decoder
`timescale 1ns/1ns
`default_nettype none
module mmap_decoder_test;
    import mmap_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic fetch = 1'b0;
    logic size_wr = 1'b0;
    logic [7:0] size_wdata = 8'h00;
    logic [5:0] vec_offset = 6'h00;
    logic vec_req = 1'b0;
    logic [7:0] mem_rdata, memory_size_select, size_model;
    logic [2:0] region;
    logic in_vector, in_table_call, in_option_byte, short_call_ok;
    logic stack_ok, fetch_fault, unmapped, vec_done;
    logic [15:0] vec_addr, vector;
    logic [31:0] seed = 32'h00008CA8;
    logic [7:0] sizes [5] = '{8'hCF, 8'h42, 8'h44, 8'hC6, 8'hC8};
    logic [15:0] bnd [24] = '{16'h0000, 16'h003F, 16'h0040, 16'h007F, 16'h0080, 16'h0081,
        16'h07FF, 16'h0800, 16'h0FFF, 16'h1000, 16'h3FFF, 16'h4000, 16'h5FFF, 16'h6000,
        16'h7FFF, 16'h8000, 16'hFAFF, 16'hFB00, 16'hFCFF, 16'hFD00, 16'hFEDF, 16'hFEE0,
        16'hFF00, 16'hFFFF};
    int errors = 0;
    int checks_done = 0;

    mmap_decoder uut (.core_clk(core_clk), .rst(rst), .addr(addr), .fetch(fetch),
        .size_wr(size_wr), .size_wdata(size_wdata), .vec_offset(vec_offset),
        .vec_req(vec_req), .mem_rdata(mem_rdata), .memory_size_select(memory_size_select),
        .region(region), .in_vector(in_vector), .in_table_call(in_table_call),
        .in_option_byte(in_option_byte), .short_call_ok(short_call_ok),
        .stack_ok(stack_ok), .fetch_fault(fetch_fault), .unmapped(unmapped),
        .vec_addr(vec_addr), .vector(vector), .vec_done(vec_done));
    mmap_mem_model mem (.vec_addr(vec_addr), .mem_rdata(mem_rdata));

    always #25 core_clk = ~core_clk;

    function logic [7:0] mbyte(input logic [15:0] a);
        return {a[3:0], a[7:4]} ^ 8'hC3;
    endfunction
    function logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function logic [2:0] exp_region(input logic [7:0] s, input logic [15:0] a);
        logic sm;
        sm = (s == 8'h42) || (s == 8'h44);
        if (a >= 16'hFF00) return MMAP_REG_SFR;
        if (a >= 16'hFEE0) return MMAP_REG_GPR;
        if (a >= (sm ? 16'hFD00 : 16'hFB00)) return MMAP_REG_RAM;
        if (a <= (sm ? 16'h3FFF : (s == 8'hC6) ? 16'h5FFF : 16'h7FFF)) return MMAP_REG_FLASH;
        return MMAP_REG_NONE;
    endfunction

    task final_report();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task dec(input logic [15:0] a, input logic f);
        logic [2:0] r;
        addr = a;
        fetch = f;
        @(negedge core_clk);
        r = exp_region(size_model, a);
        check(region, r);
        check(unmapped, r == MMAP_REG_NONE);
        check(in_vector, a <= 16'h003F);
        check(in_table_call, a >= 16'h0040 && a <= 16'h007F);
        check(in_option_byte, a == 16'h0080);
        check(short_call_ok, a >= 16'h0800 && a <= 16'h0FFF);
        check(stack_ok, r == MMAP_REG_RAM || r == MMAP_REG_GPR);
        check(fetch_fault, f && !(r == MMAP_REG_FLASH || r == MMAP_REG_RAM));
    endtask
    task vwait(input logic [15:0] b, input logic [15:0] en);
        int n;
        n = 0;
        while (vec_done !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        check(n[15:0], en);
        check(vector, {mbyte(b + 16'h0001), mbyte(b)});
    endtask
    task vec(input logic [5:0] off);
        logic [15:0] b;
        // let the done state return to idle first
        @(negedge core_clk);
        vec_offset = off;
        vec_req = 1'b1;
        @(negedge core_clk);
        vec_req = 1'b0;
        b = {10'h000, off[5:1], 1'b0};
        if (b > 16'h0030) b = 16'h0000;
        vwait(b, 16'h0002);
    endtask

    initial begin
        #(50 * 5000);
        errors++;
        final_report();
    end

    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        vwait(16'h0000, 16'h0003);
        check(memory_size_select, 8'hCF);
        for (int si = 0; si < 5; si++) begin
            size_wr = 1'b1;
            size_wdata = sizes[si];
            @(negedge core_clk);
            size_wr = 1'b0;
            size_model = sizes[si];
            check(memory_size_select, sizes[si]);
            for (int i = 0; i < 24; i++) dec(bnd[i], i[0]);
            repeat (150) begin
                seed = xs(seed);
                dec(seed[15:0], seed[16]);
            end
            $display("decode test done for size %h", size_model);
        end
        for (int o = 0; o < 64; o++) vec(o[5:0]);
        $display("vector test done");
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        vwait(16'h0000, 16'h0003);
        check(memory_size_select, 8'hCF);
        $display("second reset test done");
        final_report();
    end
endmodule
`default_nettype wire
